/* File: dv/gls_ctrl_model.sv */
// Safety controller model facing the guard lock status logic
`timescale 1ns/10ps
`default_nettype none
module gls_ctrl_model (
    input  wire logic clk,
    input  wire logic lockReq,
    input  wire logic safeA,
    input  wire logic safeB,
    output logic      solenoidOn,
    output logic      runEnable
);
    // Spring lock: the controller releases by powering the solenoid
    always_ff @(posedge clk) begin
        solenoidOn <= ~lockReq;
    end
    // Machine may run only when both channels agree on
    always_ff @(posedge clk) begin
        runEnable <= safeA & safeB;
    end
endmodule : gls_ctrl_model
`default_nettype wire

/* File: dv/test_guard_lock_status_logic.sv */
// Self-checking bench for the guard lock status logic
`timescale 1ns/10ps
`default_nettype none
`include "gls_params.svh"
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin nErrors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_guard_lock_status_logic;
    // ****************
    // Signals
    // ****************
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  avsAddress = 4'h0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [3:0]  avsByteEnable = 4'hf;
    logic        escRelease = 1'b0, gatewayPresent = 1'b0;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    logic        codeOk = 1'b0, actInserted = 1'b0, actFull = 1'b0, lockPinExt = 1'b0;
    logic        elecOk = 1'b1, auxRelease = 1'b0, tensile = 1'b0, faultDet = 1'b0;
    logic        lockReq = 1'b0, solenoidOn, runEnable;
    logic        safeA, safeB, pinRetract, door1, door2, lockedF, diagF, manF, onF;
    logic        stuckF, diagLed, ledW, ledO, lockLed, commOut;
    logic [31:0] rd;
    int          nErrors = 0;
    int          testsRun = 0;

    always #12.5 clk = ~clk;

    gls_core #(.BLINK_CYC(8)) dut (
        .clk(clk), .arst_n(arst_n), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .codeOk(codeOk),
        .actInserted(actInserted), .actFull(actFull), .lockPinExt(lockPinExt),
        .solenoidOn(solenoidOn), .elecOk(elecOk), .auxRelease(auxRelease),
        .escRelease(escRelease), .tensile(tensile), .faultDet(faultDet),
        .gatewayPresent(gatewayPresent),
        .safe_out_a(safeA), .safe_out_b(safeB), .pinRetract(pinRetract),
        .door_pos_first(door1), .door_pos_second(door2), .guard_locked_flag(lockedF),
        .diagnostic_flag(diagF), .manual_release_flag(manF), .outputs_on_flag(onF),
        .stuck_lock_flag(stuckF), .diag_indicator(diagLed), .stateLedWhite(ledW),
        .stateLedOrange(ledO), .lockLedOrange(lockLed), .commOut(commOut));

    gls_ctrl_model ctrl (.clk(clk), .lockReq(lockReq), .safeA(safeA), .safeB(safeB),
        .solenoidOn(solenoidOn), .runEnable(runEnable));

    // ****************
    // Helpers
    // ****************
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Waitrequest and read data are taken at the rising edge, before the edge updates them
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        logic w;
        w = 1'b1;
        @(posedge clk);
        avsAddress   <= a;
        avsWriteData <= wd;
        avsWrite     <= wr;
        avsRead      <= ~wr;
        for (int i = 0; i < 20 && w !== 1'b0; i++) begin
            @(posedge clk);
            w  = avsWaitRequest;
            rd = avsReadData;
        end
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
        if (w !== 1'b0) begin
            nErrors++;
            end_of_test();
        end
    endtask : bus

    // Bounded wait for one of the observed outputs to reach a level
    task automatic waitSig(input int sel, input logic v);
        logic s;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            #1;
            case (sel)
                0: s = onF;
                1: s = manF;
                2: s = stuckF;
                3: s = pinRetract;
                default: s = diagF;
            endcase
            if (s === v) return;
        end
        nErrors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, s, v);
        end_of_test();
    endtask : waitSig

    task automatic closeLocked;
        @(posedge clk);
        codeOk      <= 1'b1;
        actInserted <= 1'b1;
        actFull     <= 1'b1;
        lockPinExt  <= 1'b1;
        lockReq     <= 1'b1;
    endtask : closeLocked

    // ****************
    // Scenarios
    // ****************
    task automatic t_regs;
        bus(1'b0, `GLS_REG_CTRL, 32'h0);
        `CHK(rd, `GLS_CTRL_RST)
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(1'b0, 4'hc, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, `GLS_REG_CTRL, 32'h1);
        bus(1'b0, `GLS_REG_CTRL, 32'h0);
        `CHK(rd[0], 1'b1)
        bus(1'b1, `GLS_REG_CTRL, 32'h0);
        // Lane 0 disabled: the write must not land
        avsByteEnable <= 4'he;
        bus(1'b1, `GLS_REG_CTRL, 32'h1);
        avsByteEnable <= 4'hf;
        bus(1'b0, `GLS_REG_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        $display("t_regs done");
    endtask : t_regs

    task automatic t_unmonitored;
        @(posedge clk);
        codeOk      <= 1'b1;
        actInserted <= 1'b1;
        waitSig(0, 1'b1);
        `CHK(door1, 1'b1)
        `CHK({safeA, safeB}, 2'b11)
        `CHK(lockedF, 1'b0)
        `CHK(door2, 1'b0)
        `CHK(commOut, 1'b1)
        repeat (2) @(posedge clk);
        `CHK(runEnable, 1'b1)
        @(posedge clk);
        codeOk      <= 1'b0;
        actInserted <= 1'b0;
        waitSig(0, 1'b0);
        `CHK({safeA, safeB, door1}, 3'b000)
        $display("t_unmonitored done");
    endtask : t_unmonitored

    task automatic t_locked;
        bus(1'b1, `GLS_REG_CTRL, 32'h1);
        closeLocked();
        waitSig(0, 1'b1);
        `CHK({safeA, safeB, lockedF, door1, door2}, 5'h1f)
        bus(1'b0, `GLS_REG_STAT, 32'h0);
        `CHK(rd[5:0], 6'h27)
        @(posedge clk);
        elecOk  <= 1'b0;
        lockReq <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK({pinRetract, lockedF}, 2'b01)
        @(posedge clk);
        elecOk <= 1'b1;
        waitSig(3, 1'b1);
        @(posedge clk);
        lockPinExt <= 1'b0;
        waitSig(0, 1'b0);
        `CHK({safeA, safeB, lockedF, door1}, 4'b0001)
        $display("t_locked done");
    endtask : t_locked

    task automatic t_aux;
        logic o;
        closeLocked();
        waitSig(0, 1'b1);
        @(posedge clk);
        auxRelease <= 1'b1;
        lockPinExt <= 1'b0;
        waitSig(0, 1'b0);
        `CHK({lockedF, safeA, safeB}, 3'b000)
        waitSig(1, 1'b1);
        @(posedge clk);
        auxRelease <= 1'b0;
        lockPinExt <= 1'b1;
        waitSig(1, 1'b0);
        waitSig(0, 1'b1);
        bus(1'b1, `GLS_REG_CTRL, 32'h0);
        @(posedge clk);
        escRelease <= 1'b1;
        lockPinExt <= 1'b0;
        waitSig(1, 1'b1);
        `CHK({lockedF, ledW ^ ledO, lockLed ^ ledO}, 3'b010)
        o = ledO;
        // One blink half period later both lamps must have swapped
        repeat (8) @(posedge clk);
        #1;
        `CHK({ledW, ledO}, {o, ~o})
        @(posedge clk);
        escRelease <= 1'b0;
        lockPinExt <= 1'b1;
        waitSig(1, 1'b0);
        $display("t_aux done");
    endtask : t_aux

    task automatic t_stuck;
        bus(1'b1, `GLS_REG_CTRL, 32'h1);
        closeLocked();
        waitSig(0, 1'b1);
        @(posedge clk);
        tensile <= 1'b1;
        lockReq <= 1'b0;
        waitSig(2, 1'b1);
        `CHK(lockedF, 1'b1)
        @(posedge clk);
        tensile <= 1'b0;
        waitSig(2, 1'b0);
        @(posedge clk);
        lockReq <= 1'b1;
        $display("t_stuck done");
    endtask : t_stuck

    task automatic t_fault;
        waitSig(0, 1'b1);
        @(posedge clk);
        faultDet <= 1'b1;
        waitSig(0, 1'b0);
        waitSig(4, 1'b1);
        `CHK({safeA, safeB, diagLed, diagF}, 4'b0011)
        @(posedge clk);
        faultDet <= 1'b0;
        repeat (80) @(posedge clk);
        `CHK({onF, diagF}, 2'b01)
        bus(1'b1, `GLS_REG_CTRL, 32'h3);
        waitSig(0, 1'b1);
        `CHK({diagLed, diagF, safeA}, 3'b001)
        $display("t_fault done");
    endtask : t_fault

    // Start bit low with the guard closed proves frame mode, not plain monitoring
    task automatic t_gateway;
        bus(1'b1, `GLS_REG_ACYC, 32'h5a);
        bus(1'b0, `GLS_REG_ACYC, 32'h0);
        `CHK(rd, 32'h0000_015a)
        @(posedge clk);
        gatewayPresent <= 1'b1;
        repeat (`GLS_BIT_CYC + 100) @(posedge clk);
        #1;
        `CHK(commOut, 1'b0)
        bus(1'b0, `GLS_REG_ACYC, 32'h0);
        `CHK(rd, 32'h0000_005a)
        repeat (`GLS_BIT_CYC) @(posedge clk);
        #1;
        `CHK(commOut, 1'b1)
        @(posedge clk);
        gatewayPresent <= 1'b0;
        $display("t_gateway done");
    endtask : t_gateway

    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_regs();
        t_unmonitored();
        t_locked();
        t_aux();
        t_stuck();
        t_fault();
        t_gateway();
        end_of_test();
    end

    // Cuts a hang short well inside the cycle budget
    initial begin
        repeat (90000) @(posedge clk);
        nErrors++;
        end_of_test();
    end
endmodule : test_guard_lock_status_logic
`default_nettype wire

/* File: rtl/gls_core.sv */
// Guard lock decision logic with Avalon-MM status registers
// Contract
// - Permissible code sets first door signal
// - Lock engages when closed, solenoid unpowered
// - Fault: outputs off, diagnostic red
// - Fault check before every output switch-on
// - Taught configuration selects lock monitoring
// - Monitoring on: release drops outputs, lock flag
// - Monitoring off: opening drops outputs, door flag
// - Lock flag follows active guard locking
// - First door on insertion, held while locked
// - Second door on full insertion, ready
// - Diagnostic flag mirrors indicator condition
// - Manual release flag until command matches
// - Output flag mirrors safety outputs
// - Stuck flag while jammed under tension
// - Gateway frames, else plain monitor output
// - Retract needs electronics and solenoid power
// - Closed locked unpowered: everything on
// - Solenoid powered: lock off, outputs per mode
// - Second door off unless full insertion
// - Auxiliary release frees lock regardless
// - Release unmonitored: lock off, LEDs blink
// - Normal again after closing or solenoid
`timescale 1ns/10ps
`default_nettype none
`include "gls_params.svh"
module gls_core #(
    parameter int BLINK_CYC = `GLS_BLINK_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output logic [31:0]      avsReadData,
    output logic             avsWaitRequest,
    input  wire logic        codeOk,
    input  wire logic        actInserted,
    input  wire logic        actFull,
    input  wire logic        lockPinExt,
    input  wire logic        solenoidOn,
    input  wire logic        elecOk,
    input  wire logic        auxRelease,
    input  wire logic        escRelease,
    input  wire logic        tensile,
    input  wire logic        faultDet,
    input  wire logic        gatewayPresent,
    output logic             safe_out_a,
    output logic             safe_out_b,
    output logic             pinRetract,
    output logic             door_pos_first,
    output logic             door_pos_second,
    output logic             guard_locked_flag,
    output logic             diagnostic_flag,
    output logic             manual_release_flag,
    output logic             outputs_on_flag,
    output logic             stuck_lock_flag,
    output logic             diag_indicator,
    output logic             stateLedWhite,
    output logic             stateLedOrange,
    output logic             lockLedOrange,
    output logic             commOut
);
    // ****************
    // Reset and input synchronisation
    // ****************
    logic [1:0] rstSync_q;
    logic       rstN;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rstSync_q <= 2'b00;
        else         rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rstN = rstSync_q[1];

    gls_sense_if sense ();
    assign sense.raw = {gatewayPresent, faultDet, tensile, escRelease,
                        auxRelease, elecOk, solenoidOn, lockPinExt,
                        actFull, actInserted, codeOk};
    gls_sync u_sync (.clk(clk), .rstN(rstN), .sense(sense));

    logic snCode, snIns, snFull, snPin, snSol, snElec;
    logic snAux, snEsc, snTens, snFault, snGw;
    assign snCode  = sense.sync[`GLS_SN_CODE];
    assign snIns   = sense.sync[`GLS_SN_INS];
    assign snFull  = sense.sync[`GLS_SN_FULL];
    assign snPin   = sense.sync[`GLS_SN_PIN];
    assign snSol   = sense.sync[`GLS_SN_SOL];
    assign snElec  = sense.sync[`GLS_SN_ELEC];
    assign snAux   = sense.sync[`GLS_SN_AUX];
    assign snEsc   = sense.sync[`GLS_SN_ESC];
    assign snTens  = sense.sync[`GLS_SN_TENS];
    assign snFault = sense.sync[`GLS_SN_FAULT];
    assign snGw    = sense.sync[`GLS_SN_GW];

    // ****************
    // Register bus
    // ****************
    logic        ack_q;
    logic        lockMonEn_q;
    logic        faultClr;
    logic [7:0]  acyc_q;
    logic        acycPend_q;
    logic        acycTake;
    logic [7:0]  statusVec;
    logic        wrTaken;
    assign avsWaitRequest = (avsRead | avsWrite) & ~ack_q;
    assign wrTaken  = avsWrite & ack_q;
    assign faultClr = wrTaken && avsAddress == `GLS_REG_CTRL
                      && avsByteEnable[0] && avsWriteData[`GLS_CTRL_CLR];

    // One wait cycle per access; answer at the second edge
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN)      ack_q <= 1'b0;
        else if (ack_q) ack_q <= 1'b0;
        else            ack_q <= avsRead | avsWrite;
    end

    // Taught configuration actuator lands here
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN)
            lockMonEn_q <= 1'(`GLS_CTRL_RST);
        else if (wrTaken && avsAddress == `GLS_REG_CTRL && avsByteEnable[0])
            lockMonEn_q <= avsWriteData[`GLS_CTRL_MON];
    end

    // A new write wins over the frame taking the old byte
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            acyc_q     <= `GLS_ACYC_RST;
            acycPend_q <= 1'b0;
        end else if (wrTaken && avsAddress == `GLS_REG_ACYC && avsByteEnable[0]) begin
            acyc_q     <= avsWriteData[7:0];
            acycPend_q <= 1'b1;
        end else if (acycTake) begin
            acycPend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            avsReadData <= 32'h0000_0000;
        end else if (avsRead && !ack_q) begin
            case (avsAddress)
                `GLS_REG_CTRL: avsReadData <= {31'h0, lockMonEn_q};
                `GLS_REG_STAT: avsReadData <= {24'h0, statusVec};
                `GLS_REG_ACYC: avsReadData <= {23'h0, acycPend_q, acyc_q};
                default:       avsReadData <= 32'h0000_0000;
            endcase
        end
    end

    // ****************
    // Locking and release
    // ****************
    logic released, closed, lockActive, cmdLock, rawRetract;
    logic manRel_q;
    assign released   = snAux | snEsc;
    assign closed     = snCode & snIns;
    assign rawRetract = snElec & snSol;
    assign cmdLock    = ~snSol;
    // A release frees the pin whatever the solenoid does
    assign lockActive = snPin & closed & snFull & ~released;

    // Set wins over clear
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN)
            manRel_q <= 1'b0;
        else if (released)
            manRel_q <= 1'b1;
        else if ((cmdLock == lockActive) && (closed | snSol))
            manRel_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) pinRetract <= 1'b0;
        else       pinRetract <= rawRetract;
    end

    // ****************
    // Safety output sequencing
    // ****************
    gls_pkg::gls_state_e state_q;
    logic [5:0] chk_q;
    logic       wantOn;
    // Monitoring on needs the lock; off needs only the closed guard
    assign wantOn = lockMonEn_q ? (lockActive & snFull)
                                : closed;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_q <= gls_pkg::ST_OFF;
        end else if (snFault) begin
            state_q <= gls_pkg::ST_FAULT;
        end else begin
            case (state_q)
                gls_pkg::ST_OFF:
                    if (wantOn) state_q <= gls_pkg::ST_CHECK;
                gls_pkg::ST_CHECK:
                    if (!wantOn)
                        state_q <= gls_pkg::ST_OFF;
                    else if (chk_q == 6'(`GLS_CHECK_CYC - 1))
                        state_q <= gls_pkg::ST_ON;
                gls_pkg::ST_ON:
                    if (!wantOn) state_q <= gls_pkg::ST_OFF;
                gls_pkg::ST_FAULT:
                    if (faultClr) state_q <= gls_pkg::ST_OFF;
                default:
                    state_q <= gls_pkg::ST_FAULT;
            endcase
        end
    end

    // Fault input is watched for the full check window
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN)                          chk_q <= 6'h00;
        else if (state_q == gls_pkg::ST_CHECK) chk_q <= chk_q + 6'h01;
        else                                chk_q <= 6'h00;
    end

    // ****************
    // Status flags
    // ****************
    logic onNow, diagNow;
    assign onNow   = state_q == gls_pkg::ST_ON && wantOn && !snFault;
    assign diagNow = state_q == gls_pkg::ST_FAULT;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            safe_out_a      <= 1'b0;
            safe_out_b      <= 1'b0;
            outputs_on_flag <= 1'b0;
        end else begin
            safe_out_a      <= onNow;
            safe_out_b      <= onNow;
            outputs_on_flag <= onNow;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            door_pos_first      <= 1'b0;
            door_pos_second     <= 1'b0;
            guard_locked_flag   <= 1'b0;
            diagnostic_flag     <= 1'b0;
            manual_release_flag <= 1'b0;
            stuck_lock_flag     <= 1'b0;
        end else begin
            door_pos_first      <= closed | lockActive;
            door_pos_second     <= closed & snFull;
            guard_locked_flag   <= lockActive;
            diagnostic_flag     <= diagNow;
            manual_release_flag <= manRel_q;
            // Retract commanded but pin held by pull on the actuator
            stuck_lock_flag <= rawRetract & snPin & snTens;
        end
    end

    // ****************
    // Indicators
    // ****************
    logic [24:0] blinkCnt_q;
    logic        blink_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            blinkCnt_q <= 25'h0;
            blink_q    <= 1'b0;
        end else if (blinkCnt_q == 25'(BLINK_CYC - 1)) begin
            blinkCnt_q <= 25'h0;
            blink_q    <= ~blink_q;
        end else begin
            blinkCnt_q <= blinkCnt_q + 25'h1;
        end
    end

    logic relBlink;
    assign relBlink = manRel_q & ~lockMonEn_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            diag_indicator <= 1'b0;
            stateLedWhite  <= 1'b0;
            stateLedOrange <= 1'b0;
            lockLedOrange  <= 1'b0;
        end else begin
            // Steady while the fault persists, flashing once it is gone
            diag_indicator <= diagNow & (snFault | blink_q);
            stateLedWhite  <= relBlink ? ~blink_q : 1'b1;
            stateLedOrange <= relBlink & blink_q;
            lockLedOrange  <= relBlink ? blink_q : lockActive;
        end
    end

    // ****************
    // Communication output
    // ****************
    logic [11:0]                 bitCnt_q;
    logic [4:0]                  frmCnt_q;
    logic [`GLS_FRAME_LEN-1:0]   shift_q;
    logic                        bitTick;
    assign statusVec = {acycPend_q, stuck_lock_flag, outputs_on_flag,
                        manual_release_flag, diagnostic_flag, guard_locked_flag,
                        door_pos_second, door_pos_first};
    assign bitTick  = bitCnt_q == 12'(`GLS_BIT_CYC - 1);
    assign acycTake = bitTick && snGw && frmCnt_q == 5'h00;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN)                 bitCnt_q <= 12'h000;
        else if (!snGw || bitTick) bitCnt_q <= 12'h000;
        else                       bitCnt_q <= bitCnt_q + 12'h001;
    end

    // Frame: start bit, status byte, acyclic byte, LSB first
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            frmCnt_q <= 5'h00;
            shift_q  <= '1;
        end else if (!snGw) begin
            frmCnt_q <= 5'h00;
            shift_q  <= '1;
        end else if (bitTick) begin
            if (frmCnt_q == 5'h00) begin
                shift_q  <= {(acycPend_q ? acyc_q : 8'h00), statusVec, 1'b0};
                frmCnt_q <= 5'(`GLS_FRAME_LEN);
            end else begin
                shift_q  <= {1'b1, shift_q[`GLS_FRAME_LEN-1:1]};
                frmCnt_q <= frmCnt_q - 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) commOut <= 1'b0;
        else       commOut <= snGw ? shift_q[0] : (closed | lockActive);
    end

    // ****************
    // Assertions
    // ****************
    fault_off_a: assert property (@(posedge clk) disable iff (!rstN)
        state_q == gls_pkg::ST_FAULT |=> !safe_out_a && !safe_out_b && diagnostic_flag)
        else $error("safety outputs on during fault");
    check_first_a: assert property (@(posedge clk) disable iff (!rstN)
        state_q == gls_pkg::ST_ON && $past(state_q) != gls_pkg::ST_ON
        |-> $past(state_q) == gls_pkg::ST_CHECK && $past(chk_q) == 6'(`GLS_CHECK_CYC - 1))
        else $error("outputs enabled without full check");
    mon_release_a: assert property (@(posedge clk) disable iff (!rstN)
        lockMonEn_q && !lockActive |=> !safe_out_a && !guard_locked_flag)
        else $error("outputs on after lock release");
    open_off_a: assert property (@(posedge clk) disable iff (!rstN)
        !lockMonEn_q && !closed && !lockActive |=> !safe_out_b && !door_pos_first)
        else $error("outputs on with guard open");
    locked_flag_a: assert property (@(posedge clk) disable iff (!rstN)
        ##1 guard_locked_flag == $past(lockActive))
        else $error("lock flag does not follow lock");
    second_door_a: assert property (@(posedge clk) disable iff (!rstN)
        door_pos_second |-> $past(snFull) && $past(closed))
        else $error("second door without full insertion");
    out_flag_a: assert property (@(posedge clk) disable iff (!rstN)
        outputs_on_flag == safe_out_a && safe_out_a == safe_out_b
        && (!safe_out_a || $past(state_q) == gls_pkg::ST_ON))
        else $error("output flag differs from outputs");
    retract_pwr_a: assert property (@(posedge clk) disable iff (!rstN)
        pinRetract |-> $past(snElec) && $past(snSol))
        else $error("retract without both supplies");
    rel_flag_a: assert property (@(posedge clk) disable iff (!rstN)
        released |=> ##1 manual_release_flag)
        else $error("release flag missing");
    stuck_set_a: assert property (@(posedge clk) disable iff (!rstN)
        rawRetract && snPin && snTens |=> stuck_lock_flag)
        else $error("stuck flag missing");
endmodule : gls_core
`default_nettype wire

/* File: rtl/gls_sync.sv */
// Two-stage synchroniser bank for sensed inputs
`timescale 1ns/10ps
`default_nettype none
`include "gls_params.svh"
module gls_sync (
    input wire logic  clk,
    input wire logic  rstN,
    gls_sense_if.snk  sense
);
    logic [`GLS_NSENSE-1:0] meta_q;
    logic [`GLS_NSENSE-1:0] sync_q;

    genvar i;
    generate
        for (i = 0; i < `GLS_NSENSE; i++) begin : g_bit
            always_ff @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= sense.raw[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sense.sync = sync_q;
endmodule : gls_sync
`default_nettype wire

/* File: shared/gls_params.svh */
// Constants for the guard lock status logic
`ifndef GLS_PARAMS_SVH
`define GLS_PARAMS_SVH
// ****************
// Sensed input bits
// ****************
`define GLS_SN_CODE   0
`define GLS_SN_INS    1
`define GLS_SN_FULL   2
`define GLS_SN_PIN    3
`define GLS_SN_SOL    4
`define GLS_SN_ELEC   5
`define GLS_SN_AUX    6
`define GLS_SN_ESC    7
`define GLS_SN_TENS   8
`define GLS_SN_FAULT  9
`define GLS_SN_GW     10
`define GLS_NSENSE    11
// ****************
// Register map
// ****************
`define GLS_REG_CTRL  4'h0
`define GLS_REG_STAT  4'h4
`define GLS_REG_ACYC  4'h8
`define GLS_CTRL_MON  0
`define GLS_CTRL_CLR  1
`define GLS_CTRL_RST  32'h0000_0000
`define GLS_ACYC_RST  8'h00
// ****************
// Timing
// ****************
`define GLS_CLK_NS    25
`define GLS_CHECK_NS  1000
`define GLS_CHECK_CYC ((`GLS_CHECK_NS + `GLS_CLK_NS - 1) / `GLS_CLK_NS)
`define GLS_BIT_NS    100000
`define GLS_BIT_CYC   (`GLS_BIT_NS / `GLS_CLK_NS)
`define GLS_BLINK_MS  500
`define GLS_BLINK_CYC (`GLS_BLINK_MS * 1000000 / `GLS_CLK_NS)
`define GLS_FRAME_LEN 17
`endif

/* File: shared/gls_pkg.sv */
// Types for the guard lock status logic
`default_nettype none
package gls_pkg;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_CHECK,
        ST_ON,
        ST_FAULT
    } gls_state_e;
endpackage : gls_pkg
`default_nettype wire

/* File: shared/gls_sense_if.sv */
// Raw and synchronised sensed inputs
`timescale 1ns/10ps
`default_nettype none
`include "gls_params.svh"
interface gls_sense_if;
    logic [`GLS_NSENSE-1:0] raw;
    logic [`GLS_NSENSE-1:0] sync;
    modport src (output raw, input sync);
    modport snk (input raw, output sync);
endinterface : gls_sense_if
`default_nettype wire
